// >>> smbus_addr_pkg.sv
// Shared constants and the link state type for the SMBus address front end
package smbus_addr_pkg;

  // Address field geometry
  localparam int ADDR_W = 7;
  localparam int BYTE_W = 8;
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;
  localparam int RW_BIT = 0;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Fixed addresses and the assignable window
  localparam logic [6:0] DEFAULT_MGMT_ADDR = 7'h61;
  localparam logic [6:0] HOST_ADDR = 7'h08;
  localparam logic [6:0] ASSIGN_MIN = 7'h10;
  localparam logic [6:0] ASSIGN_MAX = 7'h7E;

  // Identifier geometry
  localparam int ID_W = 128;
  localparam int IDX_W = 5;
  localparam logic [4:0] ID_BYTES = 5'h10;
  localparam logic [7:0] RESERVED_BYTE = 8'h00;

  // Event word crossing from the link domain: kind, default flag, byte
  localparam int EV_W = 11;
  localparam int EV_KIND_LSB = 9;
  localparam int EV_DEF_BIT = 8;
  localparam logic [1:0] EV_ADDR = 2'h0;
  localparam logic [1:0] EV_DATA = 2'h1;
  localparam logic [1:0] EV_STOP = 2'h2;
  localparam logic [1:0] EV_RESTART = 2'h3;

  // Address word crossing into the link domain: valid flag and address
  localparam int CFG_W = 8;

  typedef enum logic [3:0] {
    LS_IDLE,
    LS_SHIFT_IN,
    LS_ACK_WAIT,
    LS_ACK_DRIVE,
    LS_SHIFT_OUT,
    LS_OUT_END,
    LS_MACK,
    LS_MACK_FALL,
    LS_IGNORE
  } link_state_t;

endpackage

// >>> cdc_handshake.sv
// Toggle request and acknowledge crossing for one held data word
`timescale 1ns/1ps
`default_nettype none

module cdc_handshake #(
  parameter int W = 8
) (
  input wire logic src_clk,
  input wire logic src_rst,
  input wire logic src_send,
  input wire logic [W-1:0] src_data,
  output logic src_busy,
  input wire logic dst_clk,
  input wire logic dst_rst,
  output logic dst_valid,
  output logic [W-1:0] dst_data
);

  logic req;
  logic [W-1:0] held;
  logic ack_m;
  logic ack_s;
  logic req_m;
  logic req_s;
  logic req_p;

  // Busy until the far side has echoed the toggle, so held data never moves mid-capture
  assign src_busy = req ^ ack_s;

  // Source side: latch the word, then flip the request
  always_ff @(posedge src_clk or posedge src_rst) begin
    if (src_rst) begin
      req <= 1'b0;
      held <= '0;
    end else if (src_send && !src_busy) begin
      req <= ~req;
      held <= src_data;
    end
  end

  // Acknowledge comes back through two flip-flops
  always_ff @(posedge src_clk or posedge src_rst) begin
    if (src_rst) begin
      ack_m <= 1'b0;
      ack_s <= 1'b0;
    end else begin
      ack_m <= req_p;
      ack_s <= ack_m;
    end
  end

  // Destination side: synchronise, detect the toggle, capture the stable word
  always_ff @(posedge dst_clk or posedge dst_rst) begin
    if (dst_rst) begin
      req_m <= 1'b0;
      req_s <= 1'b0;
      req_p <= 1'b0;
      dst_valid <= 1'b0;
      dst_data <= '0;
    end else begin
      req_m <= req;
      req_s <= req_m;
      req_p <= req_s;
      dst_valid <= req_s ^ req_p;
      if (req_s != req_p) begin
        dst_data <= held;
      end
    end
  end

endmodule

`default_nettype wire

// >>> smbus_addr_front.sv
// SMBus slave address matching front end with identifier readout
`timescale 1ns/1ps
`default_nettype none

module smbus_addr_front #(
  // Arbitrary value
  parameter logic [127:0] UNIQUE_DEVICE_IDENTIFIER = 128'h5A5A_0000_1111_2222_3333_4444_5555_A5A5
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic persist_enable,
  input wire logic [6:0] nv_addr,
  input wire logic nv_valid,
  output logic nv_write,
  output logic [6:0] nv_wr_addr,
  output logic nv_wr_valid,
  input wire logic assign_load,
  input wire logic [6:0] assign_addr,
  input wire logic addr_reset,
  output logic address_valid_flag,
  output logic address_resolved_flag,
  output logic [6:0] assigned_address,
  output logic addr_hit,
  output logic [6:0] hit_addr,
  output logic hit_read,
  output logic hit_default,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic restart_seen,
  output logic stop_seen,
  output logic bus_idle
);

  // Byte of the identifier at a given index, most significant first; zero past the end
  function automatic logic [7:0] id_byte(input logic [4:0] idx);
    logic [127:0] shifted;
    shifted = UNIQUE_DEVICE_IDENTIFIER >>
      ({3'h0, 5'(smbus_addr_pkg::ID_BYTES - 5'h01 - idx)} << 3);
    if (idx < smbus_addr_pkg::ID_BYTES) begin
      id_byte = shifted[7:0];
    end else begin
      id_byte = smbus_addr_pkg::RESERVED_BYTE;
    end
  endfunction

  // Assigned addresses outside the legal window are refused
  function automatic logic in_window(input logic [6:0] a);
    in_window = (a >= smbus_addr_pkg::ASSIGN_MIN) && (a <= smbus_addr_pkg::ASSIGN_MAX);
  endfunction

  // ---------------- Link domain ----------------
  logic link_rst_m;
  logic link_rst;
  logic scl_m;
  logic scl_s;
  logic scl_p;
  logic sda_m;
  logic sda_s;
  logic sda_p;
  smbus_addr_pkg::link_state_t state;
  smbus_addr_pkg::link_state_t next_state;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] tx_byte;
  logic [7:0] next_tx_byte;
  logic [4:0] tx_idx;
  logic [4:0] next_tx_idx;
  logic addr_phase;
  logic next_addr_phase;
  logic hit;
  logic next_hit;
  logic rd;
  logic next_rd;
  logic def;
  logic next_def;
  logic next_sda_oe;
  logic ev_send;
  logic next_ev_send;
  logic [10:0] ev_word;
  logic [10:0] next_ev_word;
  logic line_idle;
  logic link_valid;
  logic [6:0] link_addr;
  logic cfg_arrive;
  logic [7:0] cfg_rx;

  // Link reset asserts at once, releases on the link clock
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_rst_m <= 1'b1;
      link_rst <= 1'b1;
    end else begin
      link_rst_m <= 1'b0;
      link_rst <= link_rst_m;
    end
  end

  // Pins pass two flip-flops; a third copy gives edges
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_p <= sda_s;
    end
  end

  // Line conditions seen on synchronised samples
  wire scl_rise = scl_s & ~scl_p;
  wire scl_fall = ~scl_s & scl_p;
  wire start_cond = scl_s & scl_p & sda_p & ~sda_s;
  wire stop_cond = scl_s & scl_p & ~sda_p & sda_s;
  wire line_free = scl_s & sda_s;
  wire in_frame = (state != smbus_addr_pkg::LS_IDLE);

  // Address decode on the byte as it completes
  wire [7:0] in_byte = {shreg[6:0], sda_s};
  wire [6:0] in_addr = in_byte[smbus_addr_pkg::ADDR_MSB:smbus_addr_pkg::ADDR_LSB];
  wire in_rw = in_byte[smbus_addr_pkg::RW_BIT];
  wire hit_default_w = (in_addr == smbus_addr_pkg::DEFAULT_MGMT_ADDR);
  wire hit_assigned_w = link_valid && (in_addr == link_addr);
  wire hit_w = hit_default_w | hit_assigned_w;
  wire last_bit = (bit_cnt == smbus_addr_pkg::LAST_BIT);
  wire [7:0] first_tx = def ? id_byte(5'h00) : smbus_addr_pkg::RESERVED_BYTE;
  wire [7:0] more_tx = def ? id_byte(tx_idx) : smbus_addr_pkg::RESERVED_BYTE;

  // Bit engine: sample on rising clock, change data only after the falling clock
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_tx_byte = tx_byte;
    next_tx_idx = tx_idx;
    next_addr_phase = addr_phase;
    next_hit = hit;
    next_rd = rd;
    next_def = def;
    next_sda_oe = sda_oe;
    next_ev_send = 1'b0;
    next_ev_word = ev_word;
    if (start_cond) begin
      // A start inside a frame is a repeated start: match a fresh address
      next_state = smbus_addr_pkg::LS_SHIFT_IN;
      next_bit_cnt = 3'h0;
      next_sda_oe = 1'b0;
      next_addr_phase = 1'b1;
      next_rd = 1'b0;
      if (in_frame) begin
        next_ev_send = 1'b1;
        next_ev_word = {smbus_addr_pkg::EV_RESTART, 1'b0, smbus_addr_pkg::RESERVED_BYTE};
      end
    end else if (stop_cond) begin
      next_state = smbus_addr_pkg::LS_IDLE;
      next_sda_oe = 1'b0;
      if (in_frame) begin
        next_ev_send = 1'b1;
        next_ev_word = {smbus_addr_pkg::EV_STOP, 1'b0, smbus_addr_pkg::RESERVED_BYTE};
      end
    end else begin
      case (state)
        smbus_addr_pkg::LS_SHIFT_IN: begin
          if (scl_rise) begin
            next_shreg = in_byte;
            next_bit_cnt = bit_cnt + 3'h1;
            if (last_bit) begin
              next_state = smbus_addr_pkg::LS_ACK_WAIT;
              if (addr_phase) begin
                next_hit = hit_w;
                next_def = hit_default_w;
                next_rd = in_rw;
              end else begin
                next_ev_send = 1'b1;
                next_ev_word = {smbus_addr_pkg::EV_DATA, 1'b0, in_byte};
              end
            end
          end
        end
        smbus_addr_pkg::LS_ACK_WAIT: begin
          if (scl_fall) begin
            if (!addr_phase || hit) begin
              next_state = smbus_addr_pkg::LS_ACK_DRIVE;
              next_sda_oe = 1'b1;
              if (addr_phase) begin
                next_ev_send = 1'b1;
                next_ev_word = {smbus_addr_pkg::EV_ADDR, def, shreg};
              end
            end else begin
              next_state = smbus_addr_pkg::LS_IGNORE;
            end
          end
        end
        smbus_addr_pkg::LS_ACK_DRIVE: begin
          if (scl_fall) begin
            next_bit_cnt = 3'h0;
            next_addr_phase = 1'b0;
            if (rd) begin
              next_state = smbus_addr_pkg::LS_SHIFT_OUT;
              next_tx_byte = first_tx;
              next_tx_idx = 5'h01;
              next_sda_oe = ~first_tx[7];
            end else begin
              next_state = smbus_addr_pkg::LS_SHIFT_IN;
              next_sda_oe = 1'b0;
            end
          end
        end
        smbus_addr_pkg::LS_SHIFT_OUT: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 3'h1;
            if (last_bit) begin
              next_state = smbus_addr_pkg::LS_OUT_END;
            end
          end else if (scl_fall) begin
            next_tx_byte = {tx_byte[6:0], 1'b0};
            next_sda_oe = ~tx_byte[6];
          end
        end
        smbus_addr_pkg::LS_OUT_END: begin
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_state = smbus_addr_pkg::LS_MACK;
          end
        end
        smbus_addr_pkg::LS_MACK: begin
          if (scl_rise) begin
            // A not-acknowledge ends our part until the next start or stop
            next_state = sda_s ? smbus_addr_pkg::LS_IGNORE : smbus_addr_pkg::LS_MACK_FALL;
          end
        end
        smbus_addr_pkg::LS_MACK_FALL: begin
          if (scl_fall) begin
            next_state = smbus_addr_pkg::LS_SHIFT_OUT;
            next_bit_cnt = 3'h0;
            next_tx_byte = more_tx;
            next_sda_oe = ~more_tx[7];
            if (tx_idx < smbus_addr_pkg::ID_BYTES) begin
              next_tx_idx = tx_idx + 5'h01;
            end
          end
        end
        smbus_addr_pkg::LS_IDLE: begin
          next_sda_oe = 1'b0;
        end
        smbus_addr_pkg::LS_IGNORE: begin
          next_sda_oe = 1'b0;
        end
        default: begin
          next_state = smbus_addr_pkg::LS_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  // Engine registers
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      state <= smbus_addr_pkg::LS_IDLE;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      tx_byte <= 8'h00;
      tx_idx <= 5'h00;
      addr_phase <= 1'b0;
      hit <= 1'b0;
      rd <= 1'b0;
      def <= 1'b0;
      sda_oe <= 1'b0;
      ev_send <= 1'b0;
      ev_word <= '0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      tx_byte <= next_tx_byte;
      tx_idx <= next_tx_idx;
      addr_phase <= next_addr_phase;
      hit <= next_hit;
      rd <= next_rd;
      def <= next_def;
      sda_oe <= next_sda_oe;
      ev_send <= next_ev_send;
      ev_word <= next_ev_word;
    end
  end

  // Pin drivers: the data level is always low, only the enable moves; clock never driven
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      sda_out <= 1'b0;
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      line_idle <= 1'b1;
      link_valid <= 1'b0;
      link_addr <= 7'h00;
    end else begin
      sda_out <= 1'b0;
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      line_idle <= line_free;
      if (cfg_arrive) begin
        link_valid <= cfg_rx[7];
        link_addr <= cfg_rx[6:0];
      end
    end
  end

  // ---------------- Core domain ----------------
  logic booted;
  logic [7:0] sent_cfg;
  logic cfg_send;
  logic cfg_busy;
  logic ev_arrive;
  logic [10:0] ev_rx;
  logic idle_m;
  logic idle_s;

  // Events from the bus engine
  cdc_handshake #(.W(smbus_addr_pkg::EV_W)) u_ev_cross (
    .src_clk(link_clk),
    .src_rst(link_rst),
    .src_send(ev_send),
    .src_data(ev_word),
    .src_busy(),
    .dst_clk(ref_clk),
    .dst_rst(sys_rst),
    .dst_valid(ev_arrive),
    .dst_data(ev_rx)
  );

  // Address and valid flag toward the bus engine
  cdc_handshake #(.W(smbus_addr_pkg::CFG_W)) u_cfg_cross (
    .src_clk(ref_clk),
    .src_rst(sys_rst),
    .src_send(cfg_send),
    .src_data({address_valid_flag, assigned_address}),
    .src_busy(cfg_busy),
    .dst_clk(link_clk),
    .dst_rst(link_rst),
    .dst_valid(cfg_arrive),
    .dst_data(cfg_rx)
  );

  wire [7:0] cfg_now = {address_valid_flag, assigned_address};
  assign cfg_send = (cfg_now != sent_cfg) && !cfg_busy;
  wire [1:0] ev_kind = ev_rx[smbus_addr_pkg::EV_W-1:smbus_addr_pkg::EV_KIND_LSB];
  wire assign_ok = assign_load && in_window(assign_addr);
  wire boot_ok = persist_enable && nv_valid && in_window(nv_addr);

  // Address state; persistent copy is recalled in the first cycle after reset
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      booted <= 1'b0;
      address_valid_flag <= 1'b0;
      address_resolved_flag <= 1'b0;
      assigned_address <= 7'h00;
      nv_write <= 1'b0;
      nv_wr_addr <= 7'h00;
      nv_wr_valid <= 1'b0;
    end else begin
      booted <= 1'b1;
      nv_write <= 1'b0;
      if (!booted && boot_ok) begin
        address_valid_flag <= 1'b1;
        assigned_address <= nv_addr;
      end else if (assign_ok) begin
        address_valid_flag <= 1'b1;
        address_resolved_flag <= 1'b1;
        assigned_address <= assign_addr;
        nv_write <= persist_enable;
        nv_wr_addr <= assign_addr;
        nv_wr_valid <= 1'b1;
      end else if (addr_reset) begin
        // A persistent address stays valid; only the resolution is forgotten
        address_resolved_flag <= 1'b0;
        address_valid_flag <= address_valid_flag & persist_enable;
      end
    end
  end

  // Track what the engine holds, and report events as one-cycle pulses
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sent_cfg <= 8'h00;
      idle_m <= 1'b1;
      idle_s <= 1'b1;
      bus_idle <= 1'b1;
      addr_hit <= 1'b0;
      hit_addr <= 7'h00;
      hit_read <= 1'b0;
      hit_default <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      restart_seen <= 1'b0;
      stop_seen <= 1'b0;
    end else begin
      if (cfg_send) begin
        sent_cfg <= cfg_now;
      end
      idle_m <= line_idle;
      idle_s <= idle_m;
      bus_idle <= idle_s;
      addr_hit <= ev_arrive && (ev_kind == smbus_addr_pkg::EV_ADDR);
      rx_valid <= ev_arrive && (ev_kind == smbus_addr_pkg::EV_DATA);
      restart_seen <= ev_arrive && (ev_kind == smbus_addr_pkg::EV_RESTART);
      stop_seen <= ev_arrive && (ev_kind == smbus_addr_pkg::EV_STOP);
      if (ev_arrive && (ev_kind == smbus_addr_pkg::EV_ADDR)) begin
        hit_addr <= ev_rx[smbus_addr_pkg::ADDR_MSB:smbus_addr_pkg::ADDR_LSB];
        hit_read <= ev_rx[smbus_addr_pkg::RW_BIT];
        hit_default <= ev_rx[smbus_addr_pkg::EV_DEF_BIT];
      end
      if (ev_arrive && (ev_kind == smbus_addr_pkg::EV_DATA)) begin
        rx_data <= ev_rx[7:0];
      end
    end
  end

endmodule

`default_nettype wire

// >>> smbus_addr_front_note_unused.sv
// Intentionally empty
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> smbus_addr_front_props.sv
// Port checker for the SMBus address front end
`timescale 1ns/1ps
`default_nettype none
module smbus_addr_front_props (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic persist_enable,
  input wire logic assign_load,
  input wire logic [6:0] assign_addr,
  input wire logic addr_reset,
  input wire logic nv_write,
  input wire logic [6:0] nv_wr_addr,
  input wire logic address_valid_flag,
  input wire logic address_resolved_flag,
  input wire logic [6:0] assigned_address,
  input wire logic addr_hit,
  input wire logic [6:0] hit_addr,
  input wire logic bus_idle
);
  // Request inside the assignable window
  wire logic in_win;
  assign in_win = assign_addr >= smbus_addr_pkg::ASSIGN_MIN &&
    assign_addr <= smbus_addr_pkg::ASSIGN_MAX;
  // Slave never drives the clock, and never drives data high
  AST_CLK_FREE: assert property (@(posedge link_clk) disable iff (sys_rst)
    !scl_oe && !scl_out) else $error("clock line driven");
  AST_DATA_LOW: assert property (@(posedge link_clk) disable iff (sys_rst)
    !sda_out) else $error("data line driven high");
  // A data move with the clock high would fake a START or STOP
  AST_DATA_MOVE: assert property (@(posedge link_clk) disable iff (sys_rst)
    $changed(sda_oe) |-> !scl_in) else $error("data drive moved with clock high");
  // Boot recall owns the first edge after reset, so those edges are skipped
  AST_ASSIGN: assert property (@(posedge ref_clk) disable iff (sys_rst)
    assign_load && in_win && !$past(sys_rst) |=> address_valid_flag &&
    address_resolved_flag && assigned_address == $past(assign_addr))
    else $error("assignment not taken");
  AST_NO_ASSIGN: assert property (@(posedge ref_clk) disable iff (sys_rst)
    assign_load && !in_win && !addr_reset && !$past(sys_rst) |=>
    $stable(assigned_address) && $stable(address_valid_flag)) else $error("bad address taken");
  AST_NV_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    assign_load && in_win && persist_enable && !$past(sys_rst) |=> nv_write &&
    nv_wr_addr == $past(assign_addr)) else $error("store not written");
  AST_KEEP_VALID: assert property (@(posedge ref_clk) disable iff (sys_rst)
    addr_reset && !assign_load && !$past(sys_rst) |=> !address_resolved_flag &&
    address_valid_flag == ($past(address_valid_flag) && $past(persist_enable)))
    else $error("address reset wrong");
  AST_HIT_ADDR: assert property (@(posedge ref_clk) disable iff (sys_rst)
    addr_hit |-> hit_addr == smbus_addr_pkg::DEFAULT_MGMT_ADDR ||
    address_valid_flag && hit_addr == assigned_address) else $error("foreign address hit");
  AST_BUSY: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(scl_in) |-> ##[1:8] !bus_idle) else $error("busy bus not seen");
  AST_IDLE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (scl_in && sda_in) [*8] |-> bus_idle) else $error("idle bus not seen");
endmodule
bind smbus_addr_front smbus_addr_front_props chk (.ref_clk, .sys_rst, .link_clk, .scl_in,
  .sda_in, .scl_out, .scl_oe, .sda_out, .sda_oe, .persist_enable, .assign_load, .assign_addr,
  .addr_reset, .nv_write, .nv_wr_addr, .address_valid_flag, .address_resolved_flag,
  .assigned_address, .addr_hit, .hit_addr, .bus_idle);
`default_nettype wire

// >>> smbus_master_model.sv
// Behavioural bus master that owns clock and data of the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module smbus_master_model #(
  parameter int Q = 250
) (
  input wire logic scl,
  input wire logic sda,
  output var logic scl_oe,
  output var logic sda_oe
);
  // Both lines released: a free bus until the first START
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // START or repeated START; the only master, it makes every clock
  task automatic start();
    sda_oe = 1'b0;
    #Q scl_oe = 1'b0;
    #Q sda_oe = 1'b1;
    #Q scl_oe = 1'b1;
  endtask
  // One bit: a one is a release, never a high drive
  task automatic bit_io(input logic b, output logic r);
    sda_oe = ~b;
    #Q scl_oe = 1'b0;
    #Q r = sda;
    #Q scl_oe = 1'b1;
  endtask
  // Byte sent and read MSB first, then the acknowledge bit
  task automatic byte_io(input logic [7:0] d, input logic ack_in,
    output logic [7:0] q, output logic ack_low);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ack_in, a);
    ack_low = ~a;
  endtask
  // STOP leaves both lines released
  task automatic stop();
    sda_oe = 1'b1;
    #Q scl_oe = 1'b0;
    #Q sda_oe = 1'b0;
    #Q;
  endtask
endmodule
`default_nettype wire

// >>> smbus_addr_front_tb_top.sv
// Self-checking bench of the SMBus address front end
`timescale 1ns/1ps
`default_nettype none
module smbus_addr_front_tb_top;
  localparam logic [127:0] ID = 128'hC3A5_1E0F_7788_9900_4B2D_6C1A_F00D_3E21; // Arbitrary value
  localparam logic [6:0] DEF = smbus_addr_pkg::DEFAULT_MGMT_ADDR;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic persist_enable = 1'b1;
  logic nv_valid = 1'b1;
  logic [6:0] nv_addr = 7'h22;
  logic assign_load = 1'b0;
  logic [6:0] assign_addr = 7'h00;
  logic addr_reset = 1'b0;
  logic m_scl_oe, m_sda_oe, scl_oe, sda_oe, nv_write, address_valid_flag, mdl_valid;
  logic address_resolved_flag, addr_hit, hit_read, hit_default, rx_valid, restart_seen;
  logic stop_seen, bus_idle, nv_wr_valid;
  logic [6:0] nv_wr_addr, assigned_address, hit_addr, mdl_addr;
  logic [7:0] rx_data, last_rx;
  wire scl, sda;
  int err_total = 0;
  int check_count = 0;
  int hits = 0;
  int rxs = 0;
  int rsts = 0;
  int stops = 0;
  // Core clock and an unrelated link clock
  always #12.5 ref_clk = ~ref_clk;
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  // Open drain: low while anyone pulls, else the pull-up wins
  assign scl = ~(m_scl_oe | scl_oe);
  assign sda = ~(m_sda_oe | sda_oe);
  smbus_addr_front #(.UNIQUE_DEVICE_IDENTIFIER(ID)) dut (.ref_clk, .sys_rst, .link_clk,
    .scl_in(scl), .scl_out(), .scl_oe, .sda_in(sda), .sda_out(), .sda_oe, .persist_enable,
    .nv_addr, .nv_valid, .nv_write, .nv_wr_addr, .nv_wr_valid, .assign_load, .assign_addr,
    .addr_reset, .address_valid_flag, .address_resolved_flag, .assigned_address, .addr_hit,
    .hit_addr, .hit_read, .hit_default, .rx_valid, .rx_data, .restart_seen, .stop_seen,
    .bus_idle);
  smbus_master_model m (.scl, .sda, .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
  // Pulses last one cycle, so each shows at exactly one falling edge
  always @(negedge ref_clk) begin
    if (addr_hit === 1'b1) hits++;
    if (restart_seen === 1'b1) rsts++;
    if (stop_seen === 1'b1) stops++;
    if (rx_valid === 1'b1) begin
      rxs++;
      last_rx = rx_data;
    end
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic logic in_win(input logic [6:0] a);
    return a >= smbus_addr_pkg::ASSIGN_MIN && a <= smbus_addr_pkg::ASSIGN_MAX;
  endfunction
  function automatic logic [7:0] rd_exp(input logic id, input int i);
    return (id && i < 16) ? ID[127 - 8 * i -: 8] : 8'h00;
  endfunction
  // One assign (ld high) or address reset (ld low), checked on the next edge
  task automatic core_op(input logic ld, input logic [6:0] a);
    logic ok;
    ok = ld && in_win(a);
    @(negedge ref_clk);
    assign_load = ld;
    addr_reset = ~ld;
    assign_addr = a;
    @(negedge ref_clk);
    assign_load = 1'b0;
    addr_reset = 1'b0;
    if (ok) mdl_addr = a;
    mdl_valid = ok | (mdl_valid & (ld | persist_enable));
    if (ld) chk("nv_write", nv_write, ok & persist_enable);
    if (ok) chk("nv_wr_addr", nv_wr_addr, a);
    if (ok) chk("nv_wr_valid", nv_wr_valid, 1'b1);
    chk("valid", address_valid_flag, mdl_valid);
    chk("assigned", assigned_address, mdl_addr);
    if (ok || !ld) chk("resolved", address_resolved_flag, ld);
  endtask
  task automatic wr_frame(input logic [6:0] a, input logic hit);
    logic ak;
    logic [7:0] d, q;
    int h0, r0, s0;
    d = 8'($urandom());
    h0 = hits;
    r0 = rxs;
    s0 = stops;
    m.start();
    @(negedge ref_clk);
    chk("bus_idle", bus_idle, 1'b0);
    m.byte_io({a, 1'b0}, 1'b1, q, ak);
    chk("addr ack", ak, hit);
    if (hit) m.byte_io(d, 1'b1, q, ak);
    m.stop();
    repeat (20) @(negedge ref_clk);
    chk("bus_idle", bus_idle, 1'b1);
    chk("hits", 8'(hits - h0), hit);
    chk("stops", 8'(stops - s0), 8'h01);
    if (hit) begin
      chk("hit_default", hit_default, a == DEF);
      chk("hit_read", hit_read, 1'b0);
      chk("hit_addr", hit_addr, a);
      chk("rx count", 8'(rxs - r0), 8'h01);
      chk("rx_data", last_rx, d);
    end
    $display("write frame to %h done", a);
  endtask
  // Bad address, repeated START to a, write byte, repeated START, read
  task automatic rd_frame(input logic [6:0] a, input logic id);
    logic ak;
    logic [7:0] q;
    int r0;
    r0 = rsts;
    m.start();
    m.byte_io({smbus_addr_pkg::HOST_ADDR, 1'b0}, 1'b1, q, ak);
    chk("host ack", ak, 1'b0);
    m.start();
    m.byte_io({a, 1'b0}, 1'b1, q, ak);
    chk("restart ack", ak, 1'b1);
    m.byte_io(8'($urandom()), 1'b1, q, ak);
    m.start();
    m.byte_io({a, 1'b1}, 1'b1, q, ak);
    chk("read ack", ak, 1'b1);
    for (int i = 0; i < 17; i++) begin
      m.byte_io(8'hFF, i == 16, q, ak);
      chk("read byte", q, rd_exp(id, i));
    end
    m.stop();
    repeat (20) @(negedge ref_clk);
    chk("restarts", 8'(rsts - r0), 8'h02);
    chk("hit_read", hit_read, 1'b1);
    $display("read frame to %h done", a);
  endtask
  initial begin
    int seed;
    logic [6:0] a;
    logic [6:0] corner [5];
    corner = '{7'h0F, 7'h10, 7'h7E, 7'h7F, 7'h08};
    seed = $urandom(37575);
    mdl_addr = 7'h22;
    mdl_valid = 1'b1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("valid in reset", address_valid_flag, 1'b0);
    chk("idle in reset", bus_idle, 1'b1);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    chk("recalled valid", address_valid_flag, 1'b1);
    chk("recalled address", assigned_address, 7'h22);
    $display("boot recall done");
    for (int i = 0; i < 11; i++) begin
      a = i < 5 ? corner[i] : 7'($urandom());
      if (a == DEF) a = 7'h33;
      core_op(1'b1, a);
    end
    core_op(1'b1, 7'h3C);
    core_op(1'b0, 7'h00);
    $display("assignment tests done");
    // Configuration needs some link cycles to cross
    repeat (20) @(negedge ref_clk);
    wr_frame(DEF, 1'b1);
    wr_frame(mdl_addr, 1'b1);
    wr_frame(smbus_addr_pkg::HOST_ADDR, 1'b0);
    wr_frame(7'h5B, 1'b0);
    rd_frame(DEF, 1'b1);
    rd_frame(mdl_addr, 1'b0);
    persist_enable = 1'b0;
    core_op(1'b0, 7'h00);
    repeat (20) @(negedge ref_clk);
    wr_frame(mdl_addr, 1'b0);
    wr_frame(DEF, 1'b1);
    end_of_test();
  end
  // The run needs about 15000 cycles; a hung bus task ends here
  initial begin
    repeat (80000) @(posedge ref_clk);
    err_total++;
    end_of_test();
  end
endmodule
`default_nettype wire
